/* File: bench/dlct_pin_model.sv */
// Purpose: Far-side pins: event pins, gate inputs, external oscillator.
// Assumes: Requests arrive from the bench just after a rising mclk edge.
// Notes: A requested fall holds low 3 cycles, then returns high.
`timescale 1ns/1ps
module dlct_pin_model (
   input wire logic mclk, // System clock
   input wire logic [1:0] fall_req, // One fall per set bit
   input wire logic [1:0] gate_lvl, // Wanted gate levels
   output logic zero_event_pin, // Event pin zero
   output logic one_event_pin, // Event pin one
   output logic irq_in_zero_n, // Gate input zero
   output logic irq_in_one_n, // Gate input one
   output logic ext_osc // Free-running oscillator
);
   // =====================================================
   // Event pins
   logic [1:0] low0 = 2'h0;
   logic [1:0] low1 = 2'h0;
   // Low for 3 cycles keeps the low level above the 2-cycle minimum
   always @(posedge mclk) begin
      low0 <= fall_req[0] ? 2'h3 : low0 - 2'(low0 != 2'h0);
      low1 <= fall_req[1] ? 2'h3 : low1 - 2'(low1 != 2'h0);
   end
   assign zero_event_pin = (low0 == 2'h0);
   assign one_event_pin = (low1 == 2'h0);
   // Gate levels pass straight through
   assign irq_in_zero_n = gate_lvl[0];
   assign irq_in_one_n = gate_lvl[1];
   // Oscillator runs free, off the sampling edge, period 6 cycles
   initial begin
      ext_osc = 1'b0;
      forever begin
         repeat (3) @(negedge mclk);
         ext_osc = ~ext_osc;
      end
   end
endmodule : dlct_pin_model

/* File: bench/dual_legacy_counter_timer_config_tb.sv */
// Purpose: Self-checking bench for the two legacy counter/timers.
// Assumes: Read data one cycle after rd; run high k edges = k steps.
// Notes: Reads queue their expected byte; a monitor compares.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
   error_cnt++; $display("wrong value at %0t: got %h want %h", \
   $time, g, e); end end
module dual_legacy_counter_timer_config_tb;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   dlct_pkg::dlct_sfr_req_type req = '0;
   logic [7:0] rdata;
   logic [1:0] run = 2'h0;
   logic [1:0] clr = 2'h0;
   logic [1:0] fall = 2'h0;
   logic [1:0] gate = 2'h3;
   logic [1:0] flag;
   logic ev0, ev1, irq0, irq1, osc;
   logic rd_d = 1'b0;
   logic [7:0] exp_q [$];
   int error_cnt = 0;
   int num_checks = 0;
   logic [1:0] md [4] = '{2'h1, 2'h0, 2'h2, 2'h1};
   logic [7:0] hi0 [4] = '{8'hff, 8'hff, 8'ha0, 8'h12};
   logic [7:0] lo0 [4] = '{8'hfd, 8'hfe, 8'hfe, 8'h34};
   int kk [4] = '{5, 3, 4, 7};
   logic [7:0] hi1 [4] = '{8'h00, 8'h00, 8'ha0, 8'h12};
   logic [7:0] lo1 [4] = '{8'h02, 8'he1, 8'ha2, 8'h3b};
   logic fl [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
   logic [7:0] pexp [4] = '{8'h0c, 8'h24, 8'h03, 8'h03};
   dlct_timers dut (.mclk(mclk), .reset(reset), .sfr_req(req),
      .sfr_rdata(rdata), .zero_run(run[0]), .one_run(run[1]),
      .zero_flag_clr(clr[0]), .one_flag_clr(clr[1]),
      .irq_in_zero_n(irq0), .irq_in_one_n(irq1),
      .zero_event_pin(ev0), .one_event_pin(ev1), .ext_osc(osc),
      .zero_ovf_flag(flag[0]), .one_ovf_flag(flag[1]));
   dlct_pin_model pins (.mclk(mclk), .fall_req(fall), .gate_lvl(gate),
      .zero_event_pin(ev0), .one_event_pin(ev1), .irq_in_zero_n(irq0),
      .irq_in_one_n(irq1), .ext_osc(osc));
   // 10 MHz system clock
   initial begin
      forever #50 mclk = ~mclk;
   end
   // =====================================================
   // Monitor: read data lands one edge after the strobe
   always @(posedge mclk) rd_d <= req.rd;
   always @(negedge mclk) begin
      if (rd_d) `CHK(rdata, exp_q.pop_front())
   end
   // =====================================================
   // Tasks
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge mclk);
      req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge mclk);
      req.rd <= 1'b0;
   endtask : rd
   task automatic load(input int t, input logic [7:0] h, l);
      wr(8'h8c + 8'(t), h);
      wr(8'h8a + 8'(t), l);
   endtask : load
   task automatic check(input int t, input logic [7:0] h, l);
      rd(8'h8c + 8'(t), h);
      rd(8'h8a + 8'(t), l);
   endtask : check
   // Run mask high for exactly k sampling edges
   task automatic run_for(input logic [1:0] m, input int k);
      @(posedge mclk);
      run <= m;
      repeat (k) @(posedge mclk);
      run <= 2'h0;
   endtask : run_for
   task automatic chk_flag(input int t, input logic e);
      @(negedge mclk);
      `CHK(flag[t], e)
      @(posedge mclk);
      clr <= 2'h1 << t;
      @(posedge mclk);
      clr <= 2'h0;
      @(negedge mclk);
      `CHK(flag[t], 1'b0)
   endtask : chk_flag
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   // Hang guard
   initial begin
      repeat (50000) @(posedge mclk);
      error_cnt++;
      $display("wrong value at %0t: run hung", $time);
      end_sim();
   end
   // =====================================================
   // Main sequence
   initial begin
      logic [7:0] v;
      logic [1:0] m;
      void'($urandom(86433));
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      // Reset values, unmapped places read zero
      for (int a = 8'h88; a <= 8'h8f; a++) rd(8'(a), 8'h00);
      v = 8'($urandom);
      wr(8'h89, v);
      rd(8'h89, v);
      wr(8'h89, 8'h00);
      wr(8'h8e, 8'hff);
      rd(8'h8e, 8'h1b);
      for (int a = 8'h8a; a <= 8'h8d; a++) begin
         v = 8'($urandom);
         wr(8'(a), v);
         rd(8'(a), v);
      end
      $display("test registers done");
      // Modes 0, 1 and 2 on both timers, clock pick = system
      wr(8'h8e, 8'h18);
      for (int t = 0; t < 2; t++) begin
         for (int i = 0; i < 4; i++) begin
            wr(8'h89, 8'(md[i]) << (4 * t));
            load(t, hi0[i], lo0[i]);
            run_for(2'h1 << t, kk[i]);
            check(t, hi1[i], lo1[i]);
            chk_flag(t, fl[i]);
         end
      end
      $display("test modes done");
      // Gate: blocked while input low, open when high or gate off
      for (int t = 0; t < 2; t++) begin
         m = 2'h1 << t;
         wr(8'h89, 8'h09 << (4 * t));
         load(t, 8'h00, 8'h00);
         gate <= 2'h0;
         repeat (4) @(posedge mclk);
         run_for(m, 5);
         gate <= 2'h3;
         repeat (4) @(posedge mclk);
         run_for(m, 6);
         wr(8'h89, 8'h01 << (4 * t));
         gate <= 2'h0;
         repeat (4) @(posedge mclk);
         run_for(m, 3);
         gate <= 2'h3;
         check(t, 8'h00, 8'h09);
      end
      $display("test gate done");
      // Event pin falls counted once each; clock pick is ignored
      for (int t = 0; t < 2; t++) begin
         m = 2'h1 << t;
         wr(8'h89, 8'h05 << (4 * t));
         load(t, 8'h00, 8'h00);
         run <= m;
         repeat (3) begin
            fall <= m;
            @(posedge mclk);
            fall <= 2'h0;
            repeat (8) @(posedge mclk);
         end
         run <= 2'h0;
         check(t, 8'h00, 8'h03);
      end
      $display("test events done");
      // Every prescale choice, both timers on the shared tick
      wr(8'h89, 8'h11);
      for (int s = 0; s < 4; s++) begin
         wr(8'h8e, 8'(s));
         load(0, 8'h00, 8'h00);
         load(1, 8'h00, 8'h00);
         run_for(2'h3, 144);
         check(0, 8'h00, pexp[s]);
         check(1, 8'h00, pexp[s]);
      end
      $display("test prescaler done");
      // Split: high byte on one_run, timer one parked in mode 3
      wr(8'h8e, 8'h18);
      wr(8'h89, 8'h33);
      load(0, 8'hfe, 8'h10);
      load(1, 8'h00, 8'h55);
      run_for(2'h2, 3);
      check(0, 8'h01, 8'h10);
      check(1, 8'h00, 8'h55);
      chk_flag(1, 1'b1);
      chk_flag(0, 1'b0);
      run_for(2'h1, 4);
      check(0, 8'h01, 8'h14);
      // Split with timer one in 16-bit mode and its event source set:
      // it runs on the system clock without one_run, wraps, no flag
      load(1, 8'hff, 8'hfd);
      wr(8'h89, 8'h53);
      repeat (3) @(posedge mclk);
      wr(8'h89, 8'h33);
      check(1, 8'h00, 8'h02);
      chk_flag(1, 1'b0);
      $display("test split done");
      repeat (4) @(posedge mclk);
      `CHK(exp_q.size(), 0)
      end_sim();
   end
endmodule : dual_legacy_counter_timer_config_tb

/* File: design/dlct_pkg.sv */
// Purpose: Constants and types for the two legacy counter/timers.
// Assumes: One system clock; 8-bit special-function register port.
// Notes: Run bits and overflow flags are plain ports.
package dlct_pkg;
   // =====================================================
   // Register offsets
   localparam logic [7:0] ADDR_MODE = 8'h89;
   localparam logic [7:0] ADDR_ZERO_LO = 8'h8a;
   localparam logic [7:0] ADDR_ONE_LO = 8'h8b;
   localparam logic [7:0] ADDR_ZERO_HI = 8'h8c;
   localparam logic [7:0] ADDR_ONE_HI = 8'h8d;
   localparam logic [7:0] ADDR_CLK_SEL = 8'h8e;
   localparam logic [7:0] REG_RESET = 8'h00;
   // =====================================================
   // Field positions
   localparam int ONE_GATE_BIT = 7;
   localparam int ONE_SRC_BIT = 6;
   localparam int ONE_MODE_LSB = 4;
   localparam int ZERO_GATE_BIT = 3;
   localparam int ZERO_SRC_BIT = 2;
   localparam int ZERO_MODE_LSB = 0;
   localparam int ONE_CLK_PICK_BIT = 4;
   localparam int ZERO_CLK_PICK_BIT = 3;
   localparam int PRESCALE_LSB = 0;
   localparam logic [7:0] CLK_SEL_WMASK = 8'h1b;
   // =====================================================
   // Count limits and divisors
   localparam logic [4:0] LO5_MAX = 5'h1f;
   localparam logic [7:0] BYTE_MAX = 8'hff;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [5:0] DIV_SYS12 = 6'h0c;
   localparam logic [5:0] DIV_SYS4 = 6'h04;
   localparam logic [5:0] DIV_SYS48 = 6'h30;
   localparam logic [2:0] DIV_EXT8_LAST = 3'h7;
   // =====================================================
   // Types
   typedef enum logic [1:0] {
      MODE_13BIT = 2'h0,
      MODE_16BIT = 2'h1,
      MODE_RELOAD8 = 2'h2,
      MODE_SPLIT = 2'h3
   } dlct_mode_type;
   typedef enum logic [1:0] {
      PRE_SYS12 = 2'h0,
      PRE_SYS4 = 2'h1,
      PRE_SYS48 = 2'h2,
      PRE_EXT8 = 2'h3
   } dlct_pre_type;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dlct_sfr_req_type;
endpackage : dlct_pkg

/* File: design/dlct_prescaler.sv */
// Purpose: Shared prescaler tick for both timers.
// Assumes: ext_osc is asynchronous and slower than mclk/2.
// Notes: Tick is a one-cycle pulse.
`timescale 1ns/1ps
module dlct_prescaler (
   input wire logic mclk, // System clock
   input wire logic reset, // Sync reset, high
   input wire dlct_pkg::dlct_pre_type sel, // Prescale choice
   input wire logic ext_osc, // External oscillator pin
   output logic tick // Prescaled tick pulse
);
   logic [5:0] sys_cnt_r, sys_cnt_nxt;
   logic [2:0] ext_cnt_r, ext_cnt_nxt;
   logic [2:0] ext_sync_r, ext_sync_nxt;
   logic [5:0] div_last;
   logic ext_rise;
   logic sys_wrap;

   // =====================================================
   // Divider
   // Counter restarts when it passes a new, smaller limit
   always_comb begin
      case (sel)
         dlct_pkg::PRE_SYS4: div_last = dlct_pkg::DIV_SYS4 - 6'h01;
         dlct_pkg::PRE_SYS48: div_last = dlct_pkg::DIV_SYS48 - 6'h01;
         default: div_last = dlct_pkg::DIV_SYS12 - 6'h01;
      endcase
      ext_sync_nxt = {ext_sync_r[1:0], ext_osc};
      ext_rise = ext_sync_r[1] & ~ext_sync_r[2]; // style sync
      sys_wrap = (sys_cnt_r >= div_last);
      sys_cnt_nxt = sys_wrap ? 6'h00 : sys_cnt_r + 6'h01;
      ext_cnt_nxt = ext_rise ? ext_cnt_r + 3'h1 : ext_cnt_r;
      if (sel == dlct_pkg::PRE_EXT8) begin
         tick = ext_rise && (ext_cnt_r == dlct_pkg::DIV_EXT8_LAST);
      end else begin
         tick = sys_wrap;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         sys_cnt_r <= 6'h00;
         ext_cnt_r <= 3'h0;
         ext_sync_r <= 3'h0;
      end else begin
         sys_cnt_r <= sys_cnt_nxt;
         ext_cnt_r <= ext_cnt_nxt;
         ext_sync_r <= ext_sync_nxt;
      end
   end

   // =====================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_hold4;
      (sel == dlct_pkg::PRE_SYS4) [*4];
   endsequence
   property p_div4;
      (tick && sel == dlct_pkg::PRE_SYS4) ##1 s_hold4 |->
         tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3);
   endproperty
   a_div4: assert property (p_div4)
      else $error("divide by 4 spacing wrong");
endmodule : dlct_prescaler

/* File: design/dlct_timers.sv */
// Purpose: Timer zero and timer one with their config registers.
// Assumes: Pins are asynchronous; register port is on mclk.
// Notes: Read data appears the cycle after rd.
`timescale 1ns/1ps
module dlct_timers (
   input wire logic mclk, // System clock, 10 MHz
   input wire logic reset, // Sync reset, high
   input wire dlct_pkg::dlct_sfr_req_type sfr_req, // Register access
   output logic [7:0] sfr_rdata, // Read data, registered
   input wire logic zero_run, // Timer zero run
   input wire logic one_run, // Timer one run
   input wire logic zero_flag_clr, // Clear zero flag pulse
   input wire logic one_flag_clr, // Clear one flag pulse
   input wire logic irq_in_zero_n, // Gate input zero
   input wire logic irq_in_one_n, // Gate input one
   input wire logic zero_event_pin, // Event pin zero
   input wire logic one_event_pin, // Event pin one
   input wire logic ext_osc, // External oscillator
   output logic zero_ovf_flag, // Overflow flag zero
   output logic one_ovf_flag // Overflow flag one
);
   logic [7:0] mode_r, mode_nxt;
   logic [7:0] clk_sel_r, clk_sel_nxt;
   logic [7:0] zero_count_lo_r, zero_count_lo_nxt;
   logic [7:0] zero_count_hi_r, zero_count_hi_nxt;
   logic [7:0] one_count_lo_r, one_count_lo_nxt;
   logic [7:0] one_count_hi_r, one_count_hi_nxt;
   logic zero_ovf_r, zero_ovf_nxt;
   logic one_ovf_r, one_ovf_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [2:0] sync_r [4];
   logic [2:0] sync_nxt [4];
   logic [3:0] pin_raw;
   logic irq0_s, irq1_s, ev0_fall, ev1_fall;
   logic presc_tick;
   dlct_pkg::dlct_mode_type zero_mode, one_mode;
   logic split, zero_en, zero_tick, zero_adv;
   logic one_en, one_tick, one_adv, hi_adv;
   logic zero_wr_lo, zero_wr_hi, one_wr_lo, one_wr_hi;
   logic [16:0] zero_step, one_step;
   logic [8:0] hi_split;

   // =====================================================
   // Count step for one timer: {overflow, high, low}
   function automatic logic [16:0] step(
      input dlct_pkg::dlct_mode_type md,
      input logic [7:0] hi,
      input logic [7:0] lo
   );
      logic [16:0] res;
      res = {1'b0, hi, lo};
      case (md)
         dlct_pkg::MODE_13BIT: begin
            // Upper three low bits are left alone
            res[4:0] = lo[4:0] + 5'h01;
            if (lo[4:0] == dlct_pkg::LO5_MAX) begin
               res[15:8] = hi + dlct_pkg::BYTE_ONE;
               res[16] = (hi == dlct_pkg::BYTE_MAX);
            end
         end
         dlct_pkg::MODE_16BIT: begin
            res = {1'b0, hi, lo} + 17'h00001;
         end
         dlct_pkg::MODE_RELOAD8: begin
            if (lo == dlct_pkg::BYTE_MAX) begin
               res = {1'b1, hi, hi};
            end else begin
               res[7:0] = lo + dlct_pkg::BYTE_ONE;
            end
         end
         default: begin
            res[8:0] = {1'b0, lo} + 9'h001;
            res[16] = res[8];
            res[15:8] = hi;
         end
      endcase
      return res;
   endfunction : step

   // =====================================================
   // Pin synchronisers: gates and event pins
   // Stage 0 only feeds stage 1, stage 2 is the edge reference
   assign pin_raw = {one_event_pin, zero_event_pin,
                     irq_in_one_n, irq_in_zero_n};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_comb begin
            sync_nxt[gi] = {sync_r[gi][1:0], pin_raw[gi]};
         end
         always_ff @(posedge mclk) begin
            if (reset) begin
               sync_r[gi] <= 3'h7;
            end else begin
               sync_r[gi] <= sync_nxt[gi];
            end
         end
      end
   endgenerate
   assign irq0_s = sync_r[0][1];
   assign irq1_s = sync_r[1][1];
   assign ev0_fall = ~sync_r[2][1] & sync_r[2][2];
   assign ev1_fall = ~sync_r[3][1] & sync_r[3][2];

   // =====================================================
   // Shared prescaler
   dlct_prescaler u_prescaler (
      .mclk(mclk),
      .reset(reset),
      .sel(dlct_pkg::dlct_pre_type'(
         clk_sel_r[dlct_pkg::PRESCALE_LSB +: 2])),
      .ext_osc(ext_osc),
      .tick(presc_tick)
   );

   // =====================================================
   // Count enables and ticks
   always_comb begin
      zero_mode = dlct_pkg::dlct_mode_type'(
         mode_r[dlct_pkg::ZERO_MODE_LSB +: 2]);
      one_mode = dlct_pkg::dlct_mode_type'(
         mode_r[dlct_pkg::ONE_MODE_LSB +: 2]);
      split = (zero_mode == dlct_pkg::MODE_SPLIT);
      zero_en = zero_run & (~mode_r[dlct_pkg::ZERO_GATE_BIT]
                            | irq0_s);
      if (mode_r[dlct_pkg::ZERO_SRC_BIT]) begin
         zero_tick = ev0_fall;
      end else begin
         zero_tick = clk_sel_r[dlct_pkg::ZERO_CLK_PICK_BIT]
                     | presc_tick;
      end
      zero_adv = zero_en & zero_tick;
      // Split high byte: internal clock only, run by one_run
      hi_adv = split & one_run
               & (clk_sel_r[dlct_pkg::ZERO_CLK_PICK_BIT]
                  | presc_tick);
      // Split leaves timer one run by its mode field alone
      if (one_mode == dlct_pkg::MODE_SPLIT) begin
         one_en = 1'b0;
      end else if (split) begin
         one_en = 1'b1;
      end else begin
         one_en = one_run & (~mode_r[dlct_pkg::ONE_GATE_BIT]
                             | irq1_s);
      end
      if (mode_r[dlct_pkg::ONE_SRC_BIT] && !split) begin
         one_tick = ev1_fall;
      end else begin
         one_tick = clk_sel_r[dlct_pkg::ONE_CLK_PICK_BIT]
                    | presc_tick;
      end
      one_adv = one_en & one_tick;
   end

   // =====================================================
   // Register file and counters
   // A byte written by software wins over its count step
   always_comb begin
      zero_wr_lo = sfr_req.wr && sfr_req.addr == dlct_pkg::ADDR_ZERO_LO;
      zero_wr_hi = sfr_req.wr && sfr_req.addr == dlct_pkg::ADDR_ZERO_HI;
      one_wr_lo = sfr_req.wr && sfr_req.addr == dlct_pkg::ADDR_ONE_LO;
      one_wr_hi = sfr_req.wr && sfr_req.addr == dlct_pkg::ADDR_ONE_HI;
      zero_step = step(zero_mode, zero_count_hi_r, zero_count_lo_r);
      one_step = step(one_mode, one_count_hi_r, one_count_lo_r);
      hi_split = {1'b0, zero_count_hi_r} + 9'h001;
      mode_nxt = mode_r;
      clk_sel_nxt = clk_sel_r;
      zero_count_lo_nxt = zero_count_lo_r;
      zero_count_hi_nxt = zero_count_hi_r;
      one_count_lo_nxt = one_count_lo_r;
      one_count_hi_nxt = one_count_hi_r;
      zero_ovf_nxt = zero_ovf_r & ~zero_flag_clr;
      one_ovf_nxt = one_ovf_r & ~one_flag_clr;
      // Counting; flag sets come after clears so the set wins
      if (zero_adv) begin
         zero_count_lo_nxt = zero_step[7:0];
         if (!split) begin
            zero_count_hi_nxt = zero_step[15:8];
         end
         if (zero_step[16]) begin
            zero_ovf_nxt = 1'b1;
         end
      end
      if (hi_adv) begin
         zero_count_hi_nxt = hi_split[7:0];
         if (hi_split[8]) begin
            one_ovf_nxt = 1'b1;
         end
      end
      if (one_adv) begin
         one_count_lo_nxt = one_step[7:0];
         one_count_hi_nxt = one_step[15:8];
         if (one_step[16] && !split) begin
            one_ovf_nxt = 1'b1;
         end
      end
      // Software writes
      if (sfr_req.wr && sfr_req.addr == dlct_pkg::ADDR_MODE) begin
         mode_nxt = sfr_req.wdata;
      end
      if (sfr_req.wr && sfr_req.addr == dlct_pkg::ADDR_CLK_SEL) begin
         clk_sel_nxt = sfr_req.wdata & dlct_pkg::CLK_SEL_WMASK;
      end
      if (zero_wr_lo) begin
         zero_count_lo_nxt = sfr_req.wdata;
      end
      if (zero_wr_hi) begin
         zero_count_hi_nxt = sfr_req.wdata;
      end
      if (one_wr_lo) begin
         one_count_lo_nxt = sfr_req.wdata;
      end
      if (one_wr_hi) begin
         one_count_hi_nxt = sfr_req.wdata;
      end
      // Reads; unmapped addresses answer zero
      rdata_nxt = rdata_r;
      if (sfr_req.rd) begin
         case (sfr_req.addr)
            dlct_pkg::ADDR_MODE: rdata_nxt = mode_r;
            dlct_pkg::ADDR_CLK_SEL: rdata_nxt = clk_sel_r;
            dlct_pkg::ADDR_ZERO_LO: rdata_nxt = zero_count_lo_r;
            dlct_pkg::ADDR_ZERO_HI: rdata_nxt = zero_count_hi_r;
            dlct_pkg::ADDR_ONE_LO: rdata_nxt = one_count_lo_r;
            dlct_pkg::ADDR_ONE_HI: rdata_nxt = one_count_hi_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         mode_r <= dlct_pkg::REG_RESET;
         clk_sel_r <= dlct_pkg::REG_RESET;
         zero_count_lo_r <= dlct_pkg::REG_RESET;
         zero_count_hi_r <= dlct_pkg::REG_RESET;
         one_count_lo_r <= dlct_pkg::REG_RESET;
         one_count_hi_r <= dlct_pkg::REG_RESET;
         zero_ovf_r <= 1'b0;
         one_ovf_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         mode_r <= mode_nxt;
         clk_sel_r <= clk_sel_nxt;
         zero_count_lo_r <= zero_count_lo_nxt;
         zero_count_hi_r <= zero_count_hi_nxt;
         one_count_lo_r <= one_count_lo_nxt;
         one_count_hi_r <= one_count_hi_nxt;
         zero_ovf_r <= zero_ovf_nxt;
         one_ovf_r <= one_ovf_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign sfr_rdata = rdata_r;
   assign zero_ovf_flag = zero_ovf_r;
   assign one_ovf_flag = one_ovf_r;

   // =====================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   property p_zero_halt;
      (!zero_en && !zero_wr_lo) |=> $stable(zero_count_lo_r);
   endproperty
   a_zero_halt: assert property (p_zero_halt)
      else $error("timer zero moved while halted");

   // Pin low three samples: the fall reaches the counter on the third
   sequence s_pin_fall;
      zero_event_pin ##1 !zero_event_pin [*3];
   endsequence
   property p_event_count;
      s_pin_fall ##0 (zero_run && mode_r == 8'h05 && !sfr_req.wr
         && zero_count_lo_r != 8'hff)
      |=> zero_count_lo_r == $past(zero_count_lo_r) + 8'h01;
   endproperty
   a_event_count: assert property (p_event_count)
      else $error("event pin fall not counted");

   property p_wrap13;
      (zero_adv && zero_mode == dlct_pkg::MODE_13BIT && !sfr_req.wr
       && zero_count_hi_r == 8'hff && zero_count_lo_r[4:0] == 5'h1f)
      |=> zero_ovf_flag && zero_count_hi_r == 8'h00
          && zero_count_lo_r[4:0] == 5'h00;
   endproperty
   a_wrap13: assert property (p_wrap13)
      else $error("13-bit wrap wrong");

   property p_reload;
      (zero_adv && zero_mode == dlct_pkg::MODE_RELOAD8 && !sfr_req.wr
       && zero_count_lo_r == 8'hff)
      |=> zero_count_lo_r == $past(zero_count_hi_r)
          && $stable(zero_count_hi_r) && zero_ovf_flag;
   endproperty
   a_reload: assert property (p_reload)
      else $error("auto reload wrong");

   property p_one_idle;
      (one_mode == dlct_pkg::MODE_SPLIT && !one_wr_lo && !one_wr_hi)
      |=> $stable(one_count_lo_r) && $stable(one_count_hi_r);
   endproperty
   a_one_idle: assert property (p_one_idle)
      else $error("timer one counted in mode 3");

   property p_sys_pick;
      (zero_en && mode_r[dlct_pkg::ZERO_SRC_BIT] == 1'b0
       && clk_sel_r[dlct_pkg::ZERO_CLK_PICK_BIT]
       && zero_mode == dlct_pkg::MODE_16BIT && !sfr_req.wr)
      |=> {zero_count_hi_r, zero_count_lo_r}
          == $past({zero_count_hi_r, zero_count_lo_r}) + 16'h0001;
   endproperty
   a_sys_pick: assert property (p_sys_pick)
      else $error("system clock pick not counting");

   property p_unused_zero;
      (sfr_req.rd && sfr_req.addr == dlct_pkg::ADDR_CLK_SEL)
      |=> sfr_rdata[7:5] == 3'h0 && sfr_rdata[2] == 1'b0;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused clock select bits not zero");

   property p_load_lo;
      zero_wr_lo |=> zero_count_lo_r == $past(sfr_req.wdata);
   endproperty
   a_load_lo: assert property (p_load_lo)
      else $error("low byte write not loaded");

   property p_split_hi;
      (hi_adv && zero_count_hi_r == 8'hff && !zero_wr_hi)
      |=> one_ovf_flag && zero_count_hi_r == 8'h00;
   endproperty
   a_split_hi: assert property (p_split_hi)
      else $error("split high byte wrap wrong");

   property p_wrap16;
      (zero_adv && zero_mode == dlct_pkg::MODE_16BIT && !sfr_req.wr
       && {zero_count_hi_r, zero_count_lo_r} == 16'hffff)
      |=> zero_ovf_flag && zero_count_lo_r == 8'h00;
   endproperty
   a_wrap16: assert property (p_wrap16)
      else $error("16-bit wrap wrong");
endmodule : dlct_timers
